// ==== ppa_regs.vh ====
// Purpose: register offsets, field positions, reset values and counts for the arbiter
// Assumes: included by its bare name from the arbiter and the bench
// Notes: definitions only
`ifndef PPA_REGS_VH
`define PPA_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define PPA_OFS_CTRL 4'h0
`define PPA_OFS_EXT 4'h4
`define PPA_OFS_CFG 4'h8
`define PPA_OFS_STAT 4'hc

// ****************************************
// reset values
// ****************************************
`define PPA_CTRL_RST 8'h04
`define PPA_EXT_RST 8'h00
`define PPA_CFG_RST 8'h00

// ****************************************
// control, extension and config register fields
// ****************************************
`define PPA_B0_SEL 0
`define PPA_B1_SEL 1
`define PPA_B2_SEL_A 2
`define PPA_B2_SEL_B 3
`define PPA_B0_ROT 4
`define PPA_B1_ROT 5
`define PPA_B2_ROT 6
`define PPA_B3_ROT 7
`define PPA_B3_SEL 0
`define PPA_CFG_SIX 0
`define PPA_CTRL_MASK4 8'h77
`define PPA_EXT_MASK 8'h01

// ****************************************
// status register fields
// ****************************************
`define PPA_ST_VALID 0
`define PPA_ST_OWNER_LO 1
`define PPA_ST_LOCK 4
`define PPA_ST_ENABLED 5
`define PPA_ST_MIX 6
`define PPA_ST_B2_LO 8
`define PPA_ST_B0 10
`define PPA_ST_B1 11
`define PPA_ST_B3 12

// ****************************************
// timing
// ****************************************
`define PPA_STRAP_SETTLE 3'd4
`define PPA_SYNC_W 8

`endif

// ==== ppa_sync3.v ====
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to CLK_IN
// Notes: output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module ppa_sync3 #(
	parameter W = 8,
	parameter [W-1:0] INIT = {W{1'b1}}
)
(
	input wire clk_in,
	input wire nrst_in,
	input wire [W-1:0] async_in,
	output reg [W-1:0] stable_out
);

reg [W-1:0] stage1;
reg [W-1:0] stage2;
reg [W-1:0] stage3;

genvar i;
generate
	for (i = 0; i < W; i = i + 1)
	begin : g_bit
		always @(posedge clk_in or negedge nrst_in)
		begin
			if (!nrst_in)
			begin
				stage1[i] <= INIT[i];
				stage2[i] <= INIT[i];
				stage3[i] <= INIT[i];
				stable_out[i] <= INIT[i];
			end
			else
			begin
				stage1[i] <= async_in[i];
				stage2[i] <= stage1[i];
				stage3[i] <= stage2[i];
				// stage one only feeds stage two and is not compared here
				if (stage2[i] == stage3[i])
					stable_out[i] <= stage3[i];
			end
		end
	end
endgenerate

endmodule
`default_nettype wire

// ==== ppa_arbiter.v ====
// Purpose: programmable-priority bus arbiter, four or six masters, Avalon-MM registers
// Assumes: CLK_IN is the bus clock, NRST_IN the bus reset
// Notes: master index 0 bridge, 1 host, 2..5 external masters 0..3
//
// Functional notes
// - bridge as master never issues fast back-to-back transactions.
// - target accepts fast back-to-back; positive and subtractive decode are distinct targets.
// - four-master variant uses three two-input banks: rotating, fixed, or mixed.
// - four-master control: selects in bits 0-2, rotate enables bits 4-6.
// - four-master control resets to 04h, host first.
// - bank0 swaps bridge/master0, bank1 host/master1, bank2 the two pairs.
// - rotating bank alternates its inputs; all rotating gives pure rotation.
// - skipping an idle favoured input still toggles the bank; latency bounded.
// - all rotating, continuous requests: modes 0,5,3,6 and grants in order.
// - mixed banks: fixed ones follow select, rotating ones rotate.
// - locking master stays highest until lock and frame both released.
// - bridge request and grant stay internal while arbiter enabled.
// - six-master variant uses four banks under two registers.
// - six-master control: rotates 7-4, bank2 B/A bits 3-2, selects 1-0.
// - extension register holds bank3 select in bit 0, rest read zero.
// - six-master reset values 04h and 00h, host first.
// - bank3 swaps masters 2/3; bank2 field ranks three pairs, 11 reserved.
// - arbiter enabled when host request high at reset release.
// - six-master all banks rotating rotates all six masters.
`timescale 1ns/1ps
`default_nettype none
`include "ppa_regs.vh"

module ppa_arbiter
(
	input wire CLK_IN,
	input wire NRST_IN,
	input wire [3:0] AVS_ADDRESS_IN,
	input wire AVS_READ_IN,
	input wire AVS_WRITE_IN,
	input wire [31:0] AVS_WRITEDATA_IN,
	input wire [3:0] AVS_BYTEENABLE_IN,
	output reg [31:0] AVS_READDATA_OUT,
	output wire AVS_WAITREQUEST_OUT,
	input wire BRIDGE_SELF_REQUEST_IN,
	output wire BRIDGE_SELF_GRANT_OUT,
	input wire HOST_BRIDGE_REQUEST_N_IN,
	input wire PCI_MASTER0_REQUEST_N_IN,
	input wire PCI_MASTER1_REQUEST_N_IN,
	input wire PCI_MASTER2_REQUEST_N_IN,
	input wire PCI_MASTER3_REQUEST_N_IN,
	input wire LOCK_N_IN,
	input wire FRAME_N_IN,
	input wire EXT_BRIDGE_GRANT_N_IN,
	output reg HOST_BRIDGE_GRANT_N_OUT,
	output reg PCI_MASTER0_GRANT_N_OUT,
	output reg PCI_MASTER1_GRANT_N_OUT,
	output reg PCI_MASTER2_GRANT_N_OUT,
	output reg PCI_MASTER3_GRANT_N_OUT,
	output reg GRANT_OE_OUT,
	output reg ARB_ENABLED_OUT,
	output reg BRIDGE_FAST_B2B_OUT,
	input wire TGT_DECODE_VALID_IN,
	input wire TGT_DECODE_SUBTRACTIVE_IN,
	input wire TGT_BACK_TO_BACK_IN,
	output reg TGT_ACCEPT_OUT,
	output reg TGT_SAME_TARGET_OUT
);

// ****************************************
// pair selection helpers
// ****************************************
// returns {valid, picked b}
function [1:0] pick2;
	input ra;
	input rb;
	input pref_b;
	begin
		pick2[1] = ra | rb;
		pick2[0] = pref_b ? rb : ~ra;
	end
endfunction

function [2:0] pair_index;
	input [1:0] pair;
	input sel_b;
	begin
		case (pair)
			2'd0: pair_index = sel_b ? 3'd2 : 3'd0;
			2'd1: pair_index = sel_b ? 3'd3 : 3'd1;
			default: pair_index = sel_b ? 3'd5 : 3'd4;
		endcase
	end
endfunction

function [5:0] onehot6;
	input [2:0] idx;
	begin
		onehot6 = 6'h00;
		onehot6[idx] = 1'b1;
	end
endfunction

// ****************************************
// pin synchronisers
// ****************************************
wire [7:0] pins_s;

ppa_sync3 #(
	.W(`PPA_SYNC_W),
	.INIT(8'hff)
) u_sync (
	.clk_in(CLK_IN),
	.nrst_in(NRST_IN),
	.async_in({EXT_BRIDGE_GRANT_N_IN, FRAME_N_IN, LOCK_N_IN, PCI_MASTER3_REQUEST_N_IN,
		PCI_MASTER2_REQUEST_N_IN, PCI_MASTER1_REQUEST_N_IN, PCI_MASTER0_REQUEST_N_IN,
		HOST_BRIDGE_REQUEST_N_IN}),
	.stable_out(pins_s)
);

wire host_req_n_s = pins_s[0];
wire lock_n_s = pins_s[5];
wire frame_n_s = pins_s[6];
wire ext_bridge_grant_n_s = pins_s[7];

// ****************************************
// registers and state
// ****************************************
reg [7:0] ctrl;
reg [7:0] ext;
reg six;
reg ack;
reg strap_done;
reg [2:0] strap_cnt;
reg bridge_gnt;
reg arb_en;
reg rs0;
reg rs1;
reg rs3;
reg [1:0] rs2;
reg [5:0] gnt;
reg [2:0] owner;
reg owner_valid;
reg lock_active;
reg [2:0] lock_owner;
reg lock_n_d;
reg frame_n_d;
reg last_sub;
reg mix_flag;

// ****************************************
// request vector and bank states
// ****************************************
wire [5:0] req = {~pins_s[4] & six, ~pins_s[3] & six, ~pins_s[2], ~pins_s[1],
	~host_req_n_s, BRIDGE_SELF_REQUEST_IN};
wire rot0 = ctrl[`PPA_B0_ROT];
wire rot1 = ctrl[`PPA_B1_ROT];
wire rot2 = ctrl[`PPA_B2_ROT];
wire rot3 = six & ctrl[`PPA_B3_ROT];
wire e0 = rot0 ? rs0 : ctrl[`PPA_B0_SEL];
wire e1 = rot1 ? rs1 : ctrl[`PPA_B1_SEL];
wire e3 = rot3 ? rs3 : (six & ext[`PPA_B3_SEL]);
// reserved field 11 falls back to the bridge-pair-first order
wire [1:0] fix2 = six ? ((ctrl[3:2] == 2'b11) ? 2'b00 : ctrl[3:2]) :
	{1'b0, ctrl[`PPA_B2_SEL_A]};
wire [1:0] e2 = rot2 ? rs2 : fix2;

wire [1:0] p0 = pick2(req[0], req[2], e0);
wire [1:0] p1 = pick2(req[1], req[3], e1);
wire [1:0] p2 = pick2(req[4], req[5], e3);

reg [1:0] win_pair;
reg win_sel;
reg win_any;

// group order per bank2 state: 0 = P0,P2,P1; 1 = P1,P0,P2; 2 = P2,P1,P0
always @*
begin
	win_pair = 2'd0;
	win_sel = 1'b0;
	win_any = p0[1] | p1[1] | p2[1];
	case (e2)
		2'd1:
		begin
			if (p1[1])
			begin
				win_pair = 2'd1;
				win_sel = p1[0];
			end
			else if (p0[1])
			begin
				win_pair = 2'd0;
				win_sel = p0[0];
			end
			else
			begin
				win_pair = 2'd2;
				win_sel = p2[0];
			end
		end
		2'd2:
		begin
			if (p2[1])
			begin
				win_pair = 2'd2;
				win_sel = p2[0];
			end
			else if (p1[1])
			begin
				win_pair = 2'd1;
				win_sel = p1[0];
			end
			else
			begin
				win_pair = 2'd0;
				win_sel = p0[0];
			end
		end
		default:
		begin
			if (p0[1])
			begin
				win_pair = 2'd0;
				win_sel = p0[0];
			end
			else if (p2[1])
			begin
				win_pair = 2'd2;
				win_sel = p2[0];
			end
			else
			begin
				win_pair = 2'd1;
				win_sel = p1[0];
			end
		end
	endcase
end

wire lock_hold = lock_active & req[lock_owner];
wire [2:0] winner = lock_hold ? lock_owner : pair_index(win_pair, win_sel);
wire frame_end = frame_n_s & ~frame_n_d;
wire decide = strap_done & arb_en & (~owner_valid | ~req[owner] | frame_end);
wire [1:0] rs2_next_val = six ? ((rs2 == 2'd2) ? 2'd0 : rs2 + 2'd1) : {1'b0, ~rs2[0]};

// ****************************************
// strap capture after reset release
// ****************************************
// pin path needs four edges before its synchronised value is trustworthy
always @(posedge CLK_IN or negedge NRST_IN)
begin
	if (!NRST_IN)
	begin
		strap_cnt <= 3'd0;
		strap_done <= 1'b0;
		arb_en <= 1'b0;
	end
	else if (!strap_done)
	begin
		strap_cnt <= strap_cnt + 3'd1;
		if (strap_cnt == `PPA_STRAP_SETTLE)
		begin
			strap_done <= 1'b1;
			arb_en <= host_req_n_s;
		end
	end
end

// ****************************************
// arbitration and bank rotation
// ****************************************
always @(posedge CLK_IN or negedge NRST_IN)
begin
	if (!NRST_IN)
	begin
		gnt <= 6'h00;
		owner <= 3'd0;
		owner_valid <= 1'b0;
		rs0 <= 1'b0;
		rs1 <= 1'b0;
		rs2 <= 2'b00;
		rs3 <= 1'b0;
	end
	else
	begin
		if (decide && win_any)
		begin
			gnt <= onehot6(winner);
			owner <= winner;
			owner_valid <= 1'b1;
		end
		else if (decide)
		begin
			gnt <= 6'h00;
			owner_valid <= 1'b0;
		end
		// a bank toggles on every unlocked grant through it, also when its idle favourite was skipped
		if (decide && win_any && !lock_hold)
		begin
			if (rot2)
				rs2 <= rs2_next_val;
			if (rot0 && win_pair == 2'd0)
				rs0 <= ~rs0;
			if (rot1 && win_pair == 2'd1)
				rs1 <= ~rs1;
			if (rot3 && win_pair == 2'd2)
				rs3 <= ~rs3;
		end
		// idle banks track their fixed select so enabling rotation starts from it
		if (!rot0)
			rs0 <= ctrl[`PPA_B0_SEL];
		if (!rot1)
			rs1 <= ctrl[`PPA_B1_SEL];
		if (!rot2)
			rs2 <= fix2;
		if (!rot3)
			rs3 <= six & ext[`PPA_B3_SEL];
	end
end

// ****************************************
// lock tracking
// ****************************************
always @(posedge CLK_IN or negedge NRST_IN)
begin
	if (!NRST_IN)
	begin
		lock_active <= 1'b0;
		lock_owner <= 3'd0;
		lock_n_d <= 1'b1;
		frame_n_d <= 1'b1;
	end
	else
	begin
		lock_n_d <= lock_n_s;
		frame_n_d <= frame_n_s;
		if (!lock_n_s && lock_n_d && owner_valid)
		begin
			lock_active <= 1'b1;
			lock_owner <= owner;
		end
		else if (lock_n_s && frame_n_s)
			lock_active <= 1'b0;
	end
end

// ****************************************
// grant pins
// ****************************************
always @(posedge CLK_IN or negedge NRST_IN)
begin
	if (!NRST_IN)
	begin
		HOST_BRIDGE_GRANT_N_OUT <= 1'b1;
		PCI_MASTER0_GRANT_N_OUT <= 1'b1;
		PCI_MASTER1_GRANT_N_OUT <= 1'b1;
		PCI_MASTER2_GRANT_N_OUT <= 1'b1;
		PCI_MASTER3_GRANT_N_OUT <= 1'b1;
		GRANT_OE_OUT <= 1'b0;
		bridge_gnt <= 1'b0;
		ARB_ENABLED_OUT <= 1'b0;
		BRIDGE_FAST_B2B_OUT <= 1'b0;
	end
	else
	begin
		GRANT_OE_OUT <= strap_done;
		bridge_gnt <= arb_en & gnt[0];
		ARB_ENABLED_OUT <= arb_en;
		BRIDGE_FAST_B2B_OUT <= 1'b0;
		HOST_BRIDGE_GRANT_N_OUT <= ~(arb_en & gnt[1]);
		// with the arbiter off, the master0 grant pin carries the bridge request
		PCI_MASTER0_GRANT_N_OUT <= arb_en ? ~gnt[2] : ~BRIDGE_SELF_REQUEST_IN;
		PCI_MASTER1_GRANT_N_OUT <= ~(arb_en & gnt[3]);
		PCI_MASTER2_GRANT_N_OUT <= ~(arb_en & gnt[4]);
		PCI_MASTER3_GRANT_N_OUT <= ~(arb_en & gnt[5]);
	end
end

// bridge grant is internal while enabled, from the external arbiter otherwise
assign BRIDGE_SELF_GRANT_OUT = arb_en ? bridge_gnt : (strap_done & ~ext_bridge_grant_n_s);

// ****************************************
// target fast back-to-back
// ****************************************
always @(posedge CLK_IN or negedge NRST_IN)
begin
	if (!NRST_IN)
	begin
		TGT_ACCEPT_OUT <= 1'b0;
		TGT_SAME_TARGET_OUT <= 1'b0;
		last_sub <= 1'b0;
	end
	else
	begin
		TGT_ACCEPT_OUT <= TGT_DECODE_VALID_IN;
		TGT_SAME_TARGET_OUT <= TGT_DECODE_VALID_IN & TGT_BACK_TO_BACK_IN &
			(TGT_DECODE_SUBTRACTIVE_IN == last_sub);
		if (TGT_DECODE_VALID_IN)
			last_sub <= TGT_DECODE_SUBTRACTIVE_IN;
	end
end

// ****************************************
// Avalon-MM slave
// ****************************************
wire req_on = AVS_READ_IN | AVS_WRITE_IN;
wire wr_go = AVS_WRITE_IN & ack & AVS_BYTEENABLE_IN[0];
wire mix_set = TGT_DECODE_VALID_IN & TGT_BACK_TO_BACK_IN &
	(TGT_DECODE_SUBTRACTIVE_IN != last_sub);
wire mix_clr = wr_go & (AVS_ADDRESS_IN == `PPA_OFS_STAT) & AVS_WRITEDATA_IN[`PPA_ST_MIX];

assign AVS_WAITREQUEST_OUT = req_on & ~ack;

reg [31:0] rd_mux;

always @*
begin
	rd_mux = 32'h00000000;
	case (AVS_ADDRESS_IN)
		`PPA_OFS_CTRL: rd_mux[7:0] = six ? ctrl : (ctrl & `PPA_CTRL_MASK4);
		`PPA_OFS_EXT: rd_mux[7:0] = ext & `PPA_EXT_MASK;
		`PPA_OFS_CFG: rd_mux[`PPA_CFG_SIX] = six;
		`PPA_OFS_STAT:
		begin
			rd_mux[`PPA_ST_VALID] = owner_valid;
			rd_mux[`PPA_ST_OWNER_LO +: 3] = owner;
			rd_mux[`PPA_ST_LOCK] = lock_active;
			rd_mux[`PPA_ST_ENABLED] = arb_en;
			rd_mux[`PPA_ST_MIX] = mix_flag;
			rd_mux[`PPA_ST_B2_LO +: 2] = e2;
			rd_mux[`PPA_ST_B0] = e0;
			rd_mux[`PPA_ST_B1] = e1;
			rd_mux[`PPA_ST_B3] = e3;
		end
		default: rd_mux = 32'h00000000;
	endcase
end

always @(posedge CLK_IN or negedge NRST_IN)
begin
	if (!NRST_IN)
	begin
		ack <= 1'b0;
		AVS_READDATA_OUT <= 32'h00000000;
		ctrl <= `PPA_CTRL_RST;
		ext <= `PPA_EXT_RST;
		six <= 1'b0;
		mix_flag <= 1'b0;
	end
	else
	begin
		ack <= req_on & ~ack;
		if (AVS_READ_IN && !ack)
			AVS_READDATA_OUT <= rd_mux;
		if (wr_go && AVS_ADDRESS_IN == `PPA_OFS_CTRL)
			ctrl <= AVS_WRITEDATA_IN[7:0];
		if (wr_go && AVS_ADDRESS_IN == `PPA_OFS_EXT)
			ext <= AVS_WRITEDATA_IN[7:0] & `PPA_EXT_MASK;
		if (wr_go && AVS_ADDRESS_IN == `PPA_OFS_CFG)
			six <= AVS_WRITEDATA_IN[`PPA_CFG_SIX];
		// a new mix event beats a simultaneous clear
		if (mix_set)
			mix_flag <= 1'b1;
		else if (mix_clr)
			mix_flag <= 1'b0;
	end
end

endmodule
`default_nettype wire

// ==== ppa_arb_asserts.sv ====
// Purpose: port-level checks for the priority arbiter
// Assumes: bound to ppa_arbiter by the bench
// Notes: only the bridge grant is active high
`timescale 1ns/1ps
`default_nettype none
module ppa_arb_asserts
(
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic [3:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic [31:0] AVS_READDATA_OUT,
	input wire logic AVS_WAITREQUEST_OUT,
	input wire logic BRIDGE_SELF_GRANT_OUT,
	input wire logic HOST_BRIDGE_GRANT_N_OUT,
	input wire logic PCI_MASTER0_GRANT_N_OUT,
	input wire logic PCI_MASTER1_GRANT_N_OUT,
	input wire logic PCI_MASTER2_GRANT_N_OUT,
	input wire logic PCI_MASTER3_GRANT_N_OUT,
	input wire logic PCI_MASTER2_REQUEST_N_IN,
	input wire logic HOST_BRIDGE_REQUEST_N_IN,
	input wire logic GRANT_OE_OUT,
	input wire logic ARB_ENABLED_OUT,
	input wire logic BRIDGE_FAST_B2B_OUT,
	input wire logic TGT_DECODE_VALID_IN,
	input wire logic TGT_BACK_TO_BACK_IN,
	input wire logic TGT_ACCEPT_OUT,
	input wire logic TGT_SAME_TARGET_OUT
);
	logic [5:0] gnt;
	assign gnt = {~PCI_MASTER3_GRANT_N_OUT, ~PCI_MASTER2_GRANT_N_OUT, ~PCI_MASTER1_GRANT_N_OUT,
		~PCI_MASTER0_GRANT_N_OUT, ~HOST_BRIDGE_GRANT_N_OUT, BRIDGE_SELF_GRANT_OUT};
	default clocking dc @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);
	// ****
	// checks
	// ****
	a_no_fast_b2b: assert property (BRIDGE_FAST_B2B_OUT == 1'b0)
		else $error("bridge issued fast back-to-back");
	a_tgt_accept: assert property (TGT_DECODE_VALID_IN |=> TGT_ACCEPT_OUT)
		else $error("decode not accepted");
	a_accept_cause: assert property (TGT_ACCEPT_OUT |-> $past(TGT_DECODE_VALID_IN))
		else $error("accept without decode");
	a_same_b2b: assert property (
		TGT_SAME_TARGET_OUT |-> TGT_ACCEPT_OUT && $past(TGT_BACK_TO_BACK_IN))
		else $error("same target without back-to-back");
	a_one_grant: assert property (ARB_ENABLED_OUT |-> $onehot0(gnt))
		else $error("more than one grant");
	a_m2_needs_req: assert property (
		$fell(PCI_MASTER2_GRANT_N_OUT) |-> !$past(PCI_MASTER2_REQUEST_N_IN, 4))
		else $error("grant without request");
	a_ext_reserved: assert property (
		AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 4'h4
		|-> AVS_READDATA_OUT[31:1] == 31'h0) else $error("extension reserved bits set");
	a_strap_host: assert property (
		$rose(ARB_ENABLED_OUT) |-> $past(HOST_BRIDGE_REQUEST_N_IN, 2))
		else $error("enabled with host request low");
	// strap result and grant drive are launched by the same edge
	a_oe_follows: assert property ($rose(ARB_ENABLED_OUT) |-> $rose(GRANT_OE_OUT))
		else $error("grant drive late");
	a_off_grants: assert property (
		GRANT_OE_OUT && !ARB_ENABLED_OUT |-> gnt[5:3] == 3'h0 && !gnt[1])
		else $error("grant while disabled");
	cover property (TGT_SAME_TARGET_OUT);
	cover property ($fell(PCI_MASTER3_GRANT_N_OUT));
	cover property (GRANT_OE_OUT && !ARB_ENABLED_OUT);
endmodule
`default_nettype wire

// ==== ppa_masters.sv ====
// Purpose: requesting bus masters facing the arbiter
// Assumes: bench clock, grant vector bridge, host, master0..3
// Notes: a frame runs for six of every sixteen cycles while any grant is held
`timescale 1ns/1ps
`default_nettype none
module ppa_masters
(
	input wire logic clk_in,
	input wire logic [4:0] want_in,
	input wire logic lock_in,
	input wire logic [5:0] gnt_in,
	output logic [4:0] req_n_out = 5'h1f,
	output logic frame_n_out = 1'b1,
	output logic lock_n_out = 1'b1
);
	logic [3:0] cnt = 4'h0;
	// ten idle cycles so every frame end reaches the arbiter through its synchroniser
	always @(posedge clk_in)
	begin
		req_n_out <= ~want_in;
		lock_n_out <= ~lock_in;
		if (cnt != 4'h0 || gnt_in != 6'h0)
			cnt <= cnt + 4'h1;
		frame_n_out <= !(gnt_in != 6'h0 && cnt < 4'h6);
	end
endmodule
`default_nettype wire

// ==== test_ppa_arbiter.sv ====
// Purpose: self-checking bench for the priority arbiter
// Assumes: 20 MHz clock, offsets from ppa_regs.vh
// Notes: want bits host, master0..3; grant vector adds bridge at bit 0
`timescale 1ns/1ps
`default_nettype none
`include "ppa_regs.vh"
module test_ppa_arbiter;
	logic clk = 0;
	logic nrst = 0;
	logic [3:0] addr = 4'h0;
	logic rd = 0;
	logic wr = 0;
	logic [31:0] wd = 32'h0;
	logic breq = 0, egnt_n = 1, lock = 0, tv = 0, tb2b = 0, tsub = 0;
	logic [4:0] want = 5'h0;
	logic [31:0] q;
	wire [31:0] rdata;
	wire [4:0] req_n;
	wire wq, frame_n, lock_n, tacc, tsame, b2b, en, oe, bg, hg, g0, g1, g2, g3;
	wire [5:0] gv = {~g3, ~g2, ~g1, ~g0, ~hg, bg};
	int n_errors = 0;
	int compares = 0;
	logic [7:0] fc[3] = '{8'h04, 8'h06, 8'h00};
	int fe[3] = '{1, 3, 2};
	logic [7:0] sc[3] = '{8'h08, 8'h08, 8'h04};
	logic [7:0] se[3] = '{8'h00, 8'h01, 8'h00};
	int sx[3] = '{4, 5, 1};
	always #25 clk = ~clk;
	ppa_arbiter ppa_arbiter_inst (.CLK_IN(clk), .NRST_IN(nrst), .AVS_ADDRESS_IN(addr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wq), .BRIDGE_SELF_REQUEST_IN(breq),
		.BRIDGE_SELF_GRANT_OUT(bg), .HOST_BRIDGE_REQUEST_N_IN(req_n[0]),
		.PCI_MASTER0_REQUEST_N_IN(req_n[1]), .PCI_MASTER1_REQUEST_N_IN(req_n[2]),
		.PCI_MASTER2_REQUEST_N_IN(req_n[3]), .PCI_MASTER3_REQUEST_N_IN(req_n[4]),
		.LOCK_N_IN(lock_n), .FRAME_N_IN(frame_n), .EXT_BRIDGE_GRANT_N_IN(egnt_n),
		.HOST_BRIDGE_GRANT_N_OUT(hg), .PCI_MASTER0_GRANT_N_OUT(g0), .PCI_MASTER1_GRANT_N_OUT(g1),
		.PCI_MASTER2_GRANT_N_OUT(g2), .PCI_MASTER3_GRANT_N_OUT(g3), .GRANT_OE_OUT(oe),
		.ARB_ENABLED_OUT(en), .BRIDGE_FAST_B2B_OUT(b2b), .TGT_DECODE_VALID_IN(tv),
		.TGT_DECODE_SUBTRACTIVE_IN(tsub), .TGT_BACK_TO_BACK_IN(tb2b), .TGT_ACCEPT_OUT(tacc),
		.TGT_SAME_TARGET_OUT(tsame));
	ppa_masters ppa_masters_inst (.clk_in(clk), .want_in(want), .lock_in(lock), .gnt_in(gv),
		.req_n_out(req_n), .frame_n_out(frame_n), .lock_n_out(lock_n));
	// ****
	// tasks
	// ****
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// request held until waitrequest is seen low at a rising edge
	task bus(input logic r, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		rd <= r;
		wr <= !r;
		addr <= a;
		wd <= d;
		@(posedge clk);
		while (wq !== 1'b0 && n < 20)
		begin
			n++;
			@(posedge clk);
		end
		chk(n < 20, 1'b1);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task rchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b1, a, 32'h0);
		chk(q, e);
	endtask
	task wreg(input logic [3:0] a, input logic [31:0] d);
		bus(1'b0, a, d);
	endtask
	// bound of 40 is under three frames, so a skipped owner shows as a miss
	task wg(input int i);
		int n;
		n = 0;
		@(negedge clk);
		while (gv !== 32'h1 << i && n < 40)
		begin
			n++;
			@(negedge clk);
		end
		chk(gv, 32'h1 << i);
	endtask
	task hold(input int i);
		wg(i);
		repeat (40) @(negedge clk);
		chk(gv, 32'h1 << i);
	endtask
	task tgt(input logic b, input logic s, input logic e);
		@(posedge clk);
		tv <= 1'b1;
		tb2b <= b;
		tsub <= s;
		@(posedge clk);
		tv <= 1'b0;
		@(negedge clk);
		chk(tacc, 1'b1);
		chk(tsame, e);
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		n_errors++;
		finish_test();
	end
	// ****
	// sequence
	// ****
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rchk(`PPA_OFS_CTRL, 32'h04);
		rchk(`PPA_OFS_EXT, 32'h00);
		rchk(4'h2, 32'h0);
		chk(en, 1'b1);
		wreg(`PPA_OFS_CTRL, 32'hff);
		rchk(`PPA_OFS_CTRL, 32'h77);
		wreg(`PPA_OFS_EXT, 32'hff);
		rchk(`PPA_OFS_EXT, 32'h01);
		wreg(`PPA_OFS_CTRL, 32'h00);
		wreg(`PPA_OFS_CTRL, 32'h70);
		breq <= 1'b1;
		want <= 5'h07;
		for (int k = 0; k < 5; k++)
			wg(k % 4);
		@(posedge clk);
		breq <= 1'b0;
		wreg(`PPA_OFS_CTRL, 32'h04);
		wreg(`PPA_OFS_CTRL, 32'h44);
		for (int k = 0; k < 3; k++)
			wg(1 + k % 2);
		for (int k = 0; k < 3; k++)
		begin
			wreg(`PPA_OFS_CTRL, fc[k]);
			hold(fe[k]);
		end
		want <= 5'h19;
		wreg(`PPA_OFS_CFG, 32'h01);
		wreg(`PPA_OFS_CTRL, 32'hff);
		rchk(`PPA_OFS_CTRL, 32'hff);
		for (int k = 0; k < 3; k++)
		begin
			wreg(`PPA_OFS_CTRL, sc[k]);
			wreg(`PPA_OFS_EXT, se[k]);
			hold(sx[k]);
		end
		want <= 5'h00;
		wreg(`PPA_OFS_CFG, 32'h00);
		wreg(`PPA_OFS_CTRL, 32'h04);
		want <= 5'h02;
		wg(2);
		lock <= 1'b1;
		repeat (10) @(negedge clk);
		want <= 5'h03;
		repeat (50) @(negedge clk);
		chk(gv, 32'h4);
		lock <= 1'b0;
		wg(1);
		tgt(1'b0, 1'b0, 1'b0);
		tgt(1'b1, 1'b0, 1'b1);
		tgt(1'b1, 1'b1, 1'b0);
		bus(1'b1, `PPA_OFS_STAT, 32'h0);
		chk(q[6], 1'b1);
		@(posedge clk);
		nrst <= 1'b0;
		want <= 5'h01;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		egnt_n <= 1'b0;
		repeat (12) @(negedge clk);
		chk(en, 1'b0);
		chk(bg, 1'b1);
		finish_test();
	end
endmodule
bind ppa_arbiter ppa_arb_asserts ppa_arb_asserts_inst (.*);
`default_nettype wire
